// ---- design/rxe_rx_errors.sv ----
// Decided for this implementation: the AXI4-Lite register port.
`default_nettype none
// Function
// (R1) Sync-loss counter advances once per locked-to-searching move, GFP mode only.
// (R2) Every error counter wraps from all ones back to zero.
// (R3) Counters clear only on hard or soft reset, never on access.
// (R4) Overflow counter counts each receive FIFO overflow occurrence.
// (R5) Underrun counter counts each receive FIFO underrun occurrence.
// (R6) Flag bit 6 sets on each new minimum-size violation.
// (R7) Flag bit 5 sets on each new maximum-size violation.
// (R8) Flag bit 4 sets on each new sync loss.
// (R9) Flag bit 3 sets on each new format or destination error.
// (R10) Flag bit 2 sets on each new FIFO underrun.
// (R11) Flag bit 1 sets on each new FIFO overflow.
// (R12) Flag bit 0 sets on each new checksum or header check error.
// (R13) Flags hold until software writes one to them.
// (R14) A mask bit of one keeps its event off the summary interrupt.
// (R15) Masks never stop a flag from setting.
// (R16) A failed header check returns delineation to searching.
// (R17) Summary interrupt is high while any unmasked flag is set.
// (R18) Reserved top bit of flags and masks reads zero, ignores writes.
module rxe_rx_errors (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [rxe_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [rxe_pkg::DATA_W-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [rxe_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [rxe_pkg::DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic hec_valid,
	input wire logic hec_ok,
	input wire logic min_size_error,
	input wire logic max_size_error,
	input wire logic format_error,
	input wire logic fifo_underrun,
	input wire logic fifo_overflow,
	input wire logic checksum_error,
	output logic sync_locked,
	output logic receive_summary_interrupt
);
	// ==========================================
	// Address decode and read-data widening helpers
	function automatic logic rxe_is_mapped(input logic [rxe_pkg::ADDR_W-1:0] a);
		rxe_is_mapped = (a == rxe_pkg::OOS_CNT_OFF) || (a == rxe_pkg::OVF_CNT_OFF) ||
			(a == rxe_pkg::UDR_CNT_OFF) || (a == rxe_pkg::FLAGS_OFF) ||
			(a == rxe_pkg::MASKS_OFF) || (a == rxe_pkg::CTRL_OFF);
	endfunction

	function automatic logic [rxe_pkg::DATA_W-1:0] rxe_widen(input logic [15:0] v);
		rxe_widen = {16'h0000, v};
	endfunction

	// ==========================================
	// State
	logic aw_held;
	logic w_held;
	logic [rxe_pkg::ADDR_W-1:0] awaddr_q;
	logic [rxe_pkg::DATA_W-1:0] wdata_q;
	logic [3:0] wstrb_q;
	logic do_write;
	logic lane0;
	logic [rxe_pkg::EVT_W-1:0] flags;
	logic [rxe_pkg::EVT_W-1:0] masks;
	logic [rxe_pkg::EVT_W-1:0] next_flags;
	logic [rxe_pkg::EVT_W-1:0] evt_set;
	logic [rxe_pkg::EVT_W-1:0] evt_clr;
	logic gfp_mode;
	logic soft_clr;
	logic [rxe_pkg::CNT_W-1:0] oos_cnt;
	logic [rxe_pkg::CNT_W-1:0] ovf_cnt;
	logic [rxe_pkg::CNT_W-1:0] udr_cnt;
	rxe_pkg::rxe_sync_state_t sync_state;
	rxe_pkg::rxe_sync_state_t next_sync_state;
	logic [rxe_pkg::PRESYNC_W-1:0] presync_cnt;
	logic sync_drop;
	logic [rxe_pkg::DATA_W-1:0] rd_value;

	// ==========================================
	// AXI4-Lite write channel
	assign s_axi_awready = !aw_held;
	assign s_axi_wready = !w_held;
	assign do_write = aw_held && w_held && !s_axi_bvalid;
	assign lane0 = wstrb_q[0];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			awaddr_q <= '0;
		end else if (s_axi_awvalid && !aw_held) begin
			aw_held <= 1'b1;
			awaddr_q <= s_axi_awaddr;
		end else if (do_write) begin
			aw_held <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held <= 1'b0;
			wdata_q <= '0;
			wstrb_q <= '0;
		end else if (s_axi_wvalid && !w_held) begin
			w_held <= 1'b1;
			wdata_q <= s_axi_wdata;
			wstrb_q <= s_axi_wstrb;
		end else if (do_write) begin
			w_held <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= rxe_pkg::RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= rxe_is_mapped(awaddr_q) ? rxe_pkg::RESP_OKAY :
				rxe_pkg::RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ==========================================
	// Control: mode and soft reset
	// Soft reset is a write-one pulse; the bit itself always reads zero
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			gfp_mode <= rxe_pkg::CTRL_GFP_RST;
			soft_clr <= 1'b0;
		end else begin
			soft_clr <= do_write && lane0 && (awaddr_q == rxe_pkg::CTRL_OFF) &&
				wdata_q[rxe_pkg::CTRL_SOFT_RST_BIT];
			if (do_write && lane0 && (awaddr_q == rxe_pkg::CTRL_OFF)) begin
				gfp_mode <= wdata_q[rxe_pkg::CTRL_GFP_BIT];
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || soft_clr) begin
			masks <= rxe_pkg::MASKS_RST;
		end else if (do_write && lane0 && (awaddr_q == rxe_pkg::MASKS_OFF)) begin
			masks <= wdata_q[rxe_pkg::EVT_W-1:0]; // [R18]
		end
	end

	// ==========================================
	// Frame delineation
	always_comb begin
		next_sync_state = sync_state;
		case (sync_state)
			rxe_pkg::RXE_HUNT: begin
				if (hec_valid && hec_ok) begin
					next_sync_state = rxe_pkg::RXE_PRESYNC;
				end
			end
			rxe_pkg::RXE_PRESYNC: begin
				if (hec_valid && !hec_ok) begin
					next_sync_state = rxe_pkg::RXE_HUNT; // [R16]
				end else if (hec_valid && presync_cnt >= rxe_pkg::PRESYNC_COUNT) begin
					next_sync_state = rxe_pkg::RXE_SYNC;
				end
			end
			rxe_pkg::RXE_SYNC: begin
				if (hec_valid && !hec_ok) begin
					next_sync_state = rxe_pkg::RXE_HUNT; // [R16]
				end
			end
			default: begin
				next_sync_state = rxe_pkg::RXE_HUNT;
			end
		endcase
	end

	// Machine only runs in GFP mode; outside it there is no delineation
	always_ff @(posedge aclk) begin
		if (!aresetn || soft_clr || !gfp_mode) begin
			sync_state <= rxe_pkg::RXE_HUNT;
		end else begin
			sync_state <= next_sync_state;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || soft_clr || sync_state != rxe_pkg::RXE_PRESYNC) begin
			presync_cnt <= {{(rxe_pkg::PRESYNC_W-1){1'b0}}, 1'b1};
		end else if (hec_valid && hec_ok) begin
			presync_cnt <= presync_cnt + {{(rxe_pkg::PRESYNC_W-1){1'b0}}, 1'b1};
		end
	end

	assign sync_drop = gfp_mode && (sync_state == rxe_pkg::RXE_SYNC) &&
		(next_sync_state == rxe_pkg::RXE_HUNT); // [R1]
	assign sync_locked = (sync_state == rxe_pkg::RXE_SYNC);

	// ==========================================
	// Error counters
	rxe_wrap_counter #(.WIDTH(rxe_pkg::CNT_W)) u_oos_cnt (
		.aclk(aclk),
		.aresetn(aresetn),
		.clear(soft_clr), // [R3]
		.inc(sync_drop), // [R1]
		.count(oos_cnt)
	);

	rxe_wrap_counter #(.WIDTH(rxe_pkg::CNT_W)) u_fifo_overflow_counter (
		.aclk(aclk),
		.aresetn(aresetn),
		.clear(soft_clr), // [R3]
		.inc(fifo_overflow), // [R4]
		.count(ovf_cnt)
	);

	rxe_wrap_counter #(.WIDTH(rxe_pkg::CNT_W)) u_fifo_underrun_counter (
		.aclk(aclk),
		.aresetn(aresetn),
		.clear(soft_clr), // [R3]
		.inc(fifo_underrun), // [R5]
		.count(udr_cnt)
	);

	// ==========================================
	// Event flags and summary interrupt
	always_comb begin
		evt_set = '0;
		evt_set[rxe_pkg::EVT_MIN_SIZE] = min_size_error; // [R6]
		evt_set[rxe_pkg::EVT_MAX_SIZE] = max_size_error; // [R7]
		evt_set[rxe_pkg::EVT_SYNC_LOSS] = sync_drop; // [R8]
		evt_set[rxe_pkg::EVT_FORMAT] = format_error; // [R9]
		evt_set[rxe_pkg::EVT_UNDERRUN] = fifo_underrun; // [R10]
		evt_set[rxe_pkg::EVT_OVERFLOW] = fifo_overflow; // [R11]
		evt_set[rxe_pkg::EVT_CHECKSUM] = checksum_error; // [R12]
	end

	assign evt_clr = (do_write && lane0 && (awaddr_q == rxe_pkg::FLAGS_OFF)) ?
		wdata_q[rxe_pkg::EVT_W-1:0] : '0;
	// A new event in the clearing cycle survives: set wins
	assign next_flags = (flags & ~evt_clr) | evt_set; // [R13] [R15]

	always_ff @(posedge aclk) begin
		if (!aresetn || soft_clr) begin
			flags <= rxe_pkg::FLAGS_RST;
		end else begin
			flags <= next_flags;
		end
	end

	assign receive_summary_interrupt = |(flags & ~masks); // [R14] [R17]

	// ==========================================
	// AXI4-Lite read channel
	always_comb begin
		rd_value = '0;
		if (s_axi_araddr == rxe_pkg::OOS_CNT_OFF) begin
			rd_value = rxe_widen(oos_cnt);
		end else if (s_axi_araddr == rxe_pkg::OVF_CNT_OFF) begin
			rd_value = rxe_widen(ovf_cnt);
		end else if (s_axi_araddr == rxe_pkg::UDR_CNT_OFF) begin
			rd_value = rxe_widen(udr_cnt);
		end else if (s_axi_araddr == rxe_pkg::FLAGS_OFF) begin
			rd_value[rxe_pkg::EVT_W-1:0] = flags; // [R18]
		end else if (s_axi_araddr == rxe_pkg::MASKS_OFF) begin
			rd_value[rxe_pkg::EVT_W-1:0] = masks; // [R18]
		end else if (s_axi_araddr == rxe_pkg::CTRL_OFF) begin
			rd_value[rxe_pkg::CTRL_GFP_BIT] = gfp_mode;
		end
	end

	assign s_axi_arready = !s_axi_rvalid;

	// Reads have no side effect on counters or flags
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= rxe_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && !s_axi_rvalid) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_value; // [R3]
			s_axi_rresp <= rxe_is_mapped(s_axi_araddr) ? rxe_pkg::RESP_OKAY :
				rxe_pkg::RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ==========================================
	// Assertions
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	sequence lock_lost_s;
		gfp_mode && sync_state == rxe_pkg::RXE_SYNC && hec_valid && !hec_ok && !soft_clr;
	endsequence
	sequence hec_fail_s;
		hec_valid && !hec_ok && gfp_mode && !soft_clr &&
			sync_state != rxe_pkg::RXE_HUNT;
	endsequence

	oos_count_a: assert property (lock_lost_s |=> oos_cnt == $past(oos_cnt) + 16'h0001) // [R1]
		else $error("sync-loss counter missed a lock loss");
	oos_gfp_only_a: assert property (!gfp_mode && !soft_clr |=> $stable(oos_cnt)) // [R1]
		else $error("sync-loss counter moved outside GFP mode");
	counter_wrap_a: assert property ( // [R2]
		ovf_cnt == 16'hffff && fifo_overflow && !soft_clr |=> ovf_cnt == 16'h0000)
		else $error("overflow counter did not wrap to zero");
	counter_hold_a: assert property (!fifo_underrun && !soft_clr |=> $stable(udr_cnt)) // [R3]
		else $error("underrun counter changed without an underrun");
	soft_clear_a: assert property (soft_clr |=> oos_cnt == 16'h0000 && ovf_cnt == 16'h0000 &&
		udr_cnt == 16'h0000 && flags == 7'h00) // [R3]
		else $error("soft reset did not clear state");
	ovf_count_a: assert property ( // [R4]
		fifo_overflow && !soft_clr |=> ovf_cnt == $past(ovf_cnt) + 16'h0001)
		else $error("overflow counter missed an overflow");
	udr_count_a: assert property ( // [R5]
		fifo_underrun && !soft_clr |=> udr_cnt == $past(udr_cnt) + 16'h0001)
		else $error("underrun counter missed an underrun");
	min_flag_a: assert property (min_size_error && !soft_clr |=> flags[6]) // [R6]
		else $error("min-size flag not set");
	max_flag_a: assert property (max_size_error && !soft_clr |=> flags[5]) // [R7]
		else $error("max-size flag not set");
	sync_flag_a: assert property (lock_lost_s |=> flags[4]) // [R8]
		else $error("sync-loss flag not set");
	format_flag_a: assert property (format_error && !soft_clr |=> flags[3]) // [R9]
		else $error("format flag not set");
	udr_flag_a: assert property (fifo_underrun && !soft_clr |=> flags[2]) // [R10]
		else $error("underrun flag not set");
	ovf_flag_a: assert property (fifo_overflow && !soft_clr |=> flags[1]) // [R11]
		else $error("overflow flag not set");
	csum_flag_a: assert property (checksum_error && !soft_clr |=> flags[0]) // [R12]
		else $error("checksum flag not set");
	flag_hold_a: assert property (flags[0] && !evt_clr[0] && !soft_clr |=> flags[0]) // [R13]
		else $error("flag dropped without a write of one");
	flag_clear_a: assert property ( // [R13]
		flags[1] && evt_clr[1] && !fifo_overflow && !soft_clr |=> !flags[1])
		else $error("write of one did not clear flag");
	irq_gate_a: assert property ( // [R14]
		flags[2] && masks[2] && (flags & ~masks) == 7'h00 |-> !receive_summary_interrupt)
		else $error("masked event reached the summary interrupt");
	masked_set_a: assert property (fifo_underrun && masks[2] && !soft_clr |=> flags[2]) // [R15]
		else $error("mask blocked the flag");
	hunt_return_a: assert property (hec_fail_s |=> sync_state == rxe_pkg::RXE_HUNT) // [R16]
		else $error("header failure did not return to searching");
	irq_level_a: assert property (|(flags & ~masks) |-> receive_summary_interrupt) // [R17]
		else $error("unmasked flag without summary interrupt");
	reserved_a: assert property ( // [R18]
		s_axi_arvalid && s_axi_arready &&
		(s_axi_araddr == rxe_pkg::FLAGS_OFF || s_axi_araddr == rxe_pkg::MASKS_OFF)
		|=> s_axi_rdata[7] == 1'b0)
		else $error("reserved bit read back as one");
endmodule
`default_nettype wire

// ---- design/rxe_wrap_counter.sv ----
`default_nettype none
// ==========================================
// Wrapping event counter
module rxe_wrap_counter #(
	parameter int WIDTH = 16
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic clear,
	input wire logic inc,
	output logic [WIDTH-1:0] count
);
	// Clear beats a coincident increment, as a soft reset must win
	always_ff @(posedge aclk) begin
		if (!aresetn || clear) begin
			count <= '0;
		end else if (inc) begin
			count <= count + {{(WIDTH-1){1'b0}}, 1'b1}; // [R2]
		end
	end
endmodule
`default_nettype wire

// ---- include/rxe_pkg.sv ----
`default_nettype none
package rxe_pkg;
	// ==========================================
	// Bus geometry
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ==========================================
	// Register byte addresses
	localparam logic [ADDR_W-1:0] OOS_CNT_OFF = 12'h1e0;
	localparam logic [ADDR_W-1:0] OVF_CNT_OFF = 12'h1e4;
	localparam logic [ADDR_W-1:0] UDR_CNT_OFF = 12'h1e8;
	localparam logic [ADDR_W-1:0] FLAGS_OFF = 12'h1ec;
	localparam logic [ADDR_W-1:0] MASKS_OFF = 12'h200;
	localparam logic [ADDR_W-1:0] CTRL_OFF = 12'h204;

	// ==========================================
	// Field layouts and reset values
	localparam int CNT_W = 16;
	localparam int EVT_W = 7;
	localparam int EVT_CHECKSUM = 0;
	localparam int EVT_OVERFLOW = 1;
	localparam int EVT_UNDERRUN = 2;
	localparam int EVT_FORMAT = 3;
	localparam int EVT_SYNC_LOSS = 4;
	localparam int EVT_MAX_SIZE = 5;
	localparam int EVT_MIN_SIZE = 6;
	localparam logic [EVT_W-1:0] FLAGS_RST = 7'h00;
	localparam logic [EVT_W-1:0] MASKS_RST = 7'h7f;
	localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
	localparam int CTRL_GFP_BIT = 0;
	localparam int CTRL_SOFT_RST_BIT = 1;
	localparam logic CTRL_GFP_RST = 1'b1;

	// ==========================================
	// Delineation
	localparam int PRESYNC_W = 4;
	localparam logic [PRESYNC_W-1:0] PRESYNC_COUNT = 4'h1;

	typedef enum {
		RXE_HUNT,
		RXE_PRESYNC,
		RXE_SYNC
	} rxe_sync_state_t;
endpackage
`default_nettype wire

// ---- sim/rxe_rx_errors_tb.sv ----
`default_nettype none
`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin miscompares++; \
	$display("FAIL %s expected %h seen %h", nm, exp, got); end end
module rxe_rx_errors_tb;
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================
	// Stimulus and observation
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [11:0] awaddr = 12'h000;
	logic [11:0] araddr = 12'h000;
	logic [31:0] wdata = 32'h0;
	logic [31:0] rdata;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic hec_valid = 1'b0;
	logic hec_ok = 1'b0;
	logic [6:0] ev = 7'h00;
	logic awready, wready, bvalid, arready, rvalid, sync_locked, irq;
	logic [1:0] bresp, rresp, r;
	logic [31:0] d;
	int miscompares = 0;
	int num_checks = 0;

	always #10 aclk = ~aclk;

	// Event inputs indexed by their flag bit; bit 4 comes from delineation
	rxe_rx_errors dut_u (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.hec_valid(hec_valid), .hec_ok(hec_ok),
		.min_size_error(ev[6]), .max_size_error(ev[5]), .format_error(ev[3]),
		.fifo_underrun(ev[2]), .fifo_overflow(ev[1]), .checksum_error(ev[0]),
		.sync_locked(sync_locked), .receive_summary_interrupt(irq)
	);

	// ==========================================
	// Bus tasks
	// Ready is looked at mid-cycle so the decision never races the edge
	task automatic wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] s);
		bit ta = 0;
		bit tw = 0;
		bit tb = 0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!ta || !tw) begin
			@(negedge aclk);
			ta = ta || awready;
			tw = tw || wready;
			@(posedge aclk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
		end
		while (!tb) begin
			@(negedge aclk);
			tb = bvalid;
			s = bresp;
			@(posedge aclk);
		end
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] s);
		bit ta = 0;
		bit tr = 0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!ta) begin
			@(negedge aclk);
			ta = arready;
			@(posedge aclk);
		end
		arvalid <= 1'b0;
		while (!tr) begin
			@(negedge aclk);
			tr = rvalid;
			v = rdata;
			s = rresp;
			@(posedge aclk);
		end
		rready <= 1'b0;
	endtask

	task automatic chk_rd(input string nm, input logic [11:0] a, input logic [31:0] e);
		logic [31:0] v;
		logic [1:0] s;
		rd(a, v, s);
		`CHK(nm, e, v)
		`CHK("read resp", rxe_pkg::RESP_OKAY, s)
	endtask

	task automatic pulse(input int b);
		@(posedge aclk);
		ev[b] <= 1'b1;
		@(posedge aclk);
		ev[b] <= 1'b0;
	endtask

	task automatic hec(input logic ok);
		@(posedge aclk);
		hec_valid <= 1'b1;
		hec_ok <= ok;
		@(posedge aclk);
		hec_valid <= 1'b0;
	endtask

	task automatic chk_irq(input logic e);
		@(negedge aclk);
		`CHK("interrupt", e, irq)
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// ==========================================
	// Tests
	initial begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		chk_rd("sync count", rxe_pkg::OOS_CNT_OFF, 32'h0);
		chk_rd("masks", rxe_pkg::MASKS_OFF, 32'h7f);
		for (int b = 0; b < 7; b++) begin
			if (b != 4) begin
				pulse(b);
				chk_irq(1'b0);
				chk_rd("flags", rxe_pkg::FLAGS_OFF, 32'h1 << b);
				wr(rxe_pkg::FLAGS_OFF, 32'h1 << b, r);
				chk_rd("flags", rxe_pkg::FLAGS_OFF, 32'h0);
			end
		end
		wr(rxe_pkg::MASKS_OFF, 32'hff, r);
		chk_rd("masks", rxe_pkg::MASKS_OFF, 32'h7f);
		wr(rxe_pkg::MASKS_OFF, 32'h7e, r);
		pulse(1);
		chk_irq(1'b0);
		pulse(0);
		chk_irq(1'b1);
		wr(rxe_pkg::FLAGS_OFF, 32'h80, r);
		chk_rd("flags", rxe_pkg::FLAGS_OFF, 32'h3);
		wr(rxe_pkg::FLAGS_OFF, 32'h1, r);
		chk_irq(1'b0);
		chk_rd("flags", rxe_pkg::FLAGS_OFF, 32'h2);
		wr(rxe_pkg::FLAGS_OFF, 32'h2, r);
		chk_rd("overflow count", rxe_pkg::OVF_CNT_OFF, 32'h2);
		chk_rd("underrun count", rxe_pkg::UDR_CNT_OFF, 32'h1);
		wr(rxe_pkg::OVF_CNT_OFF, 32'hffff, r);
		chk_rd("overflow count", rxe_pkg::OVF_CNT_OFF, 32'h2);
		// Delineation: lock, lose lock, then a presync failure that must not count
		hec(1'b1);
		hec(1'b1);
		@(negedge aclk);
		`CHK("locked", 1'b1, sync_locked)
		hec(1'b0);
		@(negedge aclk);
		`CHK("locked", 1'b0, sync_locked)
		chk_rd("sync count", rxe_pkg::OOS_CNT_OFF, 32'h1);
		chk_rd("flags", rxe_pkg::FLAGS_OFF, 32'h10);
		hec(1'b1);
		hec(1'b0);
		wr(rxe_pkg::CTRL_OFF, 32'h0, r);
		hec(1'b1);
		hec(1'b1);
		hec(1'b0);
		chk_rd("sync count", rxe_pkg::OOS_CNT_OFF, 32'h1);
		wr(rxe_pkg::CTRL_OFF, 32'h1, r);
		// A full lap of the counter lands back on the old value
		@(posedge aclk);
		ev[1] <= 1'b1;
		repeat (65536) @(posedge aclk);
		ev[1] <= 1'b0;
		chk_rd("overflow count", rxe_pkg::OVF_CNT_OFF, 32'h2);
		rd(12'h100, d, r);
		`CHK("unmapped resp", rxe_pkg::RESP_SLVERR, r)
		`CHK("unmapped data", 32'h0, d)
		wr(12'h100, 32'h1, r);
		`CHK("unmapped resp", rxe_pkg::RESP_SLVERR, r)
		wr(rxe_pkg::CTRL_OFF, 32'h3, r);
		repeat (2) @(posedge aclk);
		chk_rd("overflow count", rxe_pkg::OVF_CNT_OFF, 32'h0);
		chk_rd("underrun count", rxe_pkg::UDR_CNT_OFF, 32'h0);
		chk_rd("sync count", rxe_pkg::OOS_CNT_OFF, 32'h0);
		chk_rd("flags", rxe_pkg::FLAGS_OFF, 32'h0);
		chk_rd("masks", rxe_pkg::MASKS_OFF, 32'h7f);
		conclude();
	end

	// Whole sequence needs roughly 66000 cycles
	initial begin
		repeat (100000) @(posedge aclk);
		miscompares++;
		conclude();
	end
endmodule
`undef CHK
`default_nettype wire
